// ==== src/pem_pkg.sv ====
/*
 * Shared constants and state types for the pin event and pattern match unit.
 * Assumes a 32-bit AXI4-Lite register port with byte addresses of 8 bits.
 */
package pem_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int PEM_CHANS = 8;
	localparam int PEM_SEL_W = 3;
	localparam int PEM_COND_W = 3;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_MODE = 8'h00;      // 1 = level, 0 = edge
	localparam logic [7:0] OFS_RISE_EN = 8'h04;   // Rise enable / level enable
	localparam logic [7:0] OFS_FALL_EN = 8'h08;   // Fall enable / active high
	localparam logic [7:0] OFS_RISE_FLAG = 8'h0C; // Write one to clear
	localparam logic [7:0] OFS_FALL_FLAG = 8'h10; // Write one to clear
	localparam logic [7:0] OFS_PIN_STATE = 8'h14; // Read only
	localparam logic [7:0] OFS_PM_CTRL = 8'h18;
	localparam logic [7:0] OFS_PM_SRC = 8'h1C;
	localparam logic [7:0] OFS_PM_CFG = 8'h20;
	localparam logic [7:0] OFS_PM_END = 8'h24;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h28;  // Cleared by read
	localparam logic [7:0] OFS_IRQ_MASK = 8'h2C;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int PM_CTRL_ON_BIT = 0;
	localparam int PM_CTRL_EV_BIT = 1;
	localparam int PIN_STATE_REQ_LSB = 8;

	// ----------------------------------------------------------------
	// Slice condition codes
	// ----------------------------------------------------------------
	localparam logic [2:0] COND_ALWAYS = 3'h0;
	localparam logic [2:0] COND_STK_RISE = 3'h1;
	localparam logic [2:0] COND_STK_FALL = 3'h2;
	localparam logic [2:0] COND_STK_EDGE = 3'h3;
	localparam logic [2:0] COND_HIGH = 3'h4;
	localparam logic [2:0] COND_LOW = 3'h5;
	localparam logic [2:0] COND_NEVER = 3'h6;
	localparam logic [2:0] COND_EDGE_NOW = 3'h7;

	// ----------------------------------------------------------------
	// Bus answers
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// State types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic s1;   // First synchroniser stage
		logic s2;   // Second stage, the clean level
		logic s3;   // Previous clean sample
	} pem_sync_type;

	typedef struct packed {
		logic rise_seen;
		logic fall_seen;
	} pem_slice_type;

	typedef struct packed {
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic aw_rdy;
		logic w_rdy;
		logic bvalid;
		logic [1:0] bresp;
		logic ar_rdy;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [7:0] mode;
		logic [7:0] rise_en;
		logic [7:0] fall_en;
		logic [7:0] rise_flag;
		logic [7:0] fall_flag;
		logic pm_on;
		logic ev_en;
		logic [23:0] pm_src;
		logic [23:0] pm_cfg;
		logic [7:0] pm_end;
		logic [7:0] irq_stat;
		logic [7:0] irq_mask;
		logic [7:0] chan_req;
		logic [7:0] term_prev;
		logic wake;
		logic cpu_event;
		logic irq;
	} pem_state_type;

	localparam pem_sync_type PEM_SYNC_RST = '0;
	localparam pem_slice_type PEM_SLICE_RST = '0;
	localparam pem_state_type PEM_STATE_RST = '0;

endpackage : pem_pkg

// ==== src/pem_sync.sv ====
/*
 * One pin input: two-stage synchroniser plus a previous sample for edges.
 * Assumes the raw pin may change at any time relative to aclk.
 */
`timescale 1ns/1ns
module pem_sync
	import pem_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic pin_raw,
	output logic lvl,
	output logic rise,
	output logic fall
);

	pem_sync_type s_r;   // Registered state
	pem_sync_type s_nxt; // Next state

	// Shift the pin through the stages
	always_comb begin
		s_nxt = s_r;
		s_nxt.s1 = pin_raw;
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2;
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= PEM_SYNC_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign lvl = s_r.s2;
	assign rise = s_r.s2 & ~s_r.s3;
	assign fall = ~s_r.s2 & s_r.s3;

endmodule : pem_sync

// ==== src/pem_slice.sv ====
/*
 * One bit slice of the pattern engine: evaluates one condition on one pin.
 * Assumes lvl, rise and fall come from a synchronised channel.
 */
`timescale 1ns/1ns
module pem_slice
	import pem_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic lvl,
	input wire logic rise,
	input wire logic fall,
	input wire logic [2:0] cond,
	input wire logic clr,
	output logic hit
);

	pem_slice_type s_r;   // Sticky edge memory
	pem_slice_type s_nxt; // Next state

	// Sticky edges; a new edge wins over a clear
	always_comb begin
		s_nxt = s_r;
		s_nxt.rise_seen = (s_r.rise_seen & ~clr) | rise;
		s_nxt.fall_seen = (s_r.fall_seen & ~clr) | fall;
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= PEM_SLICE_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	always_comb begin
		unique case (cond)
			COND_ALWAYS: hit = 1'b1;
			COND_STK_RISE: hit = s_r.rise_seen | rise;
			COND_STK_FALL: hit = s_r.fall_seen | fall;
			COND_STK_EDGE: hit = s_r.rise_seen | s_r.fall_seen | rise | fall;
			COND_HIGH: hit = lvl;
			COND_LOW: hit = ~lvl;
			COND_NEVER: hit = 1'b0;
			COND_EDGE_NOW: hit = rise | fall;
		endcase
	end

endmodule : pem_slice

// ==== src/pem_top.sv ====
/*
 * Pin event unit with pattern match engine and AXI4-Lite register port.
 * Assumes pins are already routed to pin_in by the system config block,
 * and that irq_chan feeds the core interrupt controller line by line.
 */
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
// What this block does
// - Eight pin channels, edge or level each
// - In pin mode every channel drives its own request line
// - Edge channels fire on rise, fall, both
// - Level channels request while at active level
// - Pending pin request raises the wake output
// - Eight slices form a boolean pin expression
// - Each product term drives its own request
// - Pattern match may pulse the CPU event
// - Pattern mode never raises the wake output
// - Registers answer promptly on the register bus
`timescale 1ns/1ns
module pem_top
	import pem_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] pin_in,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic [7:0] irq_chan,
	output logic wake,
	output logic cpu_event_input,
	output logic irq
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	pem_state_type s_r;   // All registered state
	pem_state_type s_nxt; // Next state
	logic [7:0] pin_lvl;  // Clean pin levels
	logic [7:0] pin_rise; // One-cycle rise pulses
	logic [7:0] pin_fall; // One-cycle fall pulses
	logic [7:0] sl_lvl;   // Slice source level
	logic [7:0] sl_rise;  // Slice source rise
	logic [7:0] sl_fall;  // Slice source fall
	logic [7:0] sl_hit;   // Slice results
	logic [7:0] term;     // Product term results at endpoints
	logic [7:0] pin_req;  // Pin mode requests
	logic pm_clr;         // Clear sticky slice edges
	logic wr_go;          // Write performed this cycle
	logic rd_go;          // Read taken this cycle

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Merge write data under byte strobes
	function automatic logic [31:0] strb_merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = data[8*b +: 8];
			end
		end
		return res;
	endfunction : strb_merge

	// Address is one of the mapped words
	function automatic logic is_mapped(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a <= OFS_IRQ_MASK);
	endfunction : is_mapped

	// ----------------------------------------------------------------
	// Pin channels
	// ----------------------------------------------------------------

	for (genvar i = 0; i < PEM_CHANS; i++) begin : g_chan
		pem_sync u_sync (
			.aclk(aclk),
			.aresetn(aresetn),
			.pin_raw(pin_in[i]),
			.lvl(pin_lvl[i]),
			.rise(pin_rise[i]),
			.fall(pin_fall[i])
		);
	end

	// ----------------------------------------------------------------
	// Pattern slices
	// ----------------------------------------------------------------

	for (genvar i = 0; i < PEM_CHANS; i++) begin : g_slice
		assign sl_lvl[i] = pin_lvl[s_r.pm_src[PEM_SEL_W*i +: PEM_SEL_W]];
		assign sl_rise[i] = pin_rise[s_r.pm_src[PEM_SEL_W*i +: PEM_SEL_W]];
		assign sl_fall[i] = pin_fall[s_r.pm_src[PEM_SEL_W*i +: PEM_SEL_W]];
		pem_slice u_slice (
			.aclk(aclk),
			.aresetn(aresetn),
			.lvl(sl_lvl[i]),
			.rise(sl_rise[i]),
			.fall(sl_fall[i]),
			.cond(s_r.pm_cfg[PEM_COND_W*i +: PEM_COND_W]),
			.clr(pm_clr),
			.hit(sl_hit[i])
		);
	end

	always_comb begin
		logic prod;
		prod = 1'b1;
		term = 8'h00;
		for (int i = 0; i < PEM_CHANS; i++) begin
			prod = prod & sl_hit[i];
			if (s_r.pm_end[i] || (i == PEM_CHANS - 1)) begin
				term[i] = prod;
				prod = 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Pin interrupt requests
	// ----------------------------------------------------------------

	always_comb begin
		for (int i = 0; i < PEM_CHANS; i++) begin
			if (s_r.mode[i]) begin
				pin_req[i] = s_r.rise_en[i] & (pin_lvl[i] == s_r.fall_en[i]);
			end else begin
				pin_req[i] = (s_r.rise_flag[i] & s_r.rise_en[i]) |
					(s_r.fall_flag[i] & s_r.fall_en[i]);
			end
		end
	end

	// ----------------------------------------------------------------
	// Bus strobes
	// ----------------------------------------------------------------
	assign wr_go = s_r.aw_got && s_r.w_got && !s_r.bvalid;
	assign rd_go = s_axi_arvalid && s_r.ar_rdy;
	assign pm_clr = wr_go && ((s_r.aw_addr == OFS_PM_CTRL) ||
		(s_r.aw_addr == OFS_PM_SRC) || (s_r.aw_addr == OFS_PM_CFG));

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [31:0] wv;
		logic [7:0] w1c;
		logic [7:0] req;
		logic rd_clr;
		wv = 32'h0000_0000;
		w1c = 8'h00;
		req = 8'h00;
		rd_clr = 1'b0;
		s_nxt = s_r;

		// address and data taken in any order
		if (s_axi_awvalid && s_r.aw_rdy) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_r.w_rdy) begin
			s_nxt.w_got = 1'b1;
			s_nxt.w_data = s_axi_wdata;
			s_nxt.w_strb = s_axi_wstrb;
		end

		// write one cycle after both halves
		if (wr_go) begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = is_mapped(s_r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
			unique case (s_r.aw_addr)
				OFS_MODE: begin
					wv = strb_merge({24'h00_0000, s_r.mode}, s_r.w_data, s_r.w_strb);
					s_nxt.mode = wv[7:0];
				end
				OFS_RISE_EN: begin
					wv = strb_merge({24'h00_0000, s_r.rise_en}, s_r.w_data, s_r.w_strb);
					s_nxt.rise_en = wv[7:0];
				end
				OFS_FALL_EN: begin
					wv = strb_merge({24'h00_0000, s_r.fall_en}, s_r.w_data, s_r.w_strb);
					s_nxt.fall_en = wv[7:0];
				end
				OFS_PM_CTRL: begin
					wv = strb_merge({30'h0000_0000, s_r.ev_en, s_r.pm_on},
						s_r.w_data, s_r.w_strb);
					s_nxt.pm_on = wv[PM_CTRL_ON_BIT];
					s_nxt.ev_en = wv[PM_CTRL_EV_BIT];
				end
				OFS_PM_SRC: begin
					wv = strb_merge({8'h00, s_r.pm_src}, s_r.w_data, s_r.w_strb);
					s_nxt.pm_src = wv[23:0];
				end
				OFS_PM_CFG: begin
					wv = strb_merge({8'h00, s_r.pm_cfg}, s_r.w_data, s_r.w_strb);
					s_nxt.pm_cfg = wv[23:0];
				end
				OFS_PM_END: begin
					wv = strb_merge({24'h00_0000, s_r.pm_end}, s_r.w_data, s_r.w_strb);
					s_nxt.pm_end = wv[7:0];
				end
				OFS_IRQ_MASK: begin
					wv = strb_merge({24'h00_0000, s_r.irq_mask}, s_r.w_data, s_r.w_strb);
					s_nxt.irq_mask = wv[7:0];
				end
				default: begin
					wv = 32'h0000_0000;
				end
			endcase
		end

		// Response drained
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end
		s_nxt.aw_rdy = !s_nxt.aw_got && !s_nxt.bvalid;
		s_nxt.w_rdy = !s_nxt.w_got && !s_nxt.bvalid;

		// read data from the taken address
		if (rd_go) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			unique case (s_axi_araddr)
				OFS_MODE: s_nxt.rdata = {24'h00_0000, s_r.mode};
				OFS_RISE_EN: s_nxt.rdata = {24'h00_0000, s_r.rise_en};
				OFS_FALL_EN: s_nxt.rdata = {24'h00_0000, s_r.fall_en};
				OFS_RISE_FLAG: s_nxt.rdata = {24'h00_0000, s_r.rise_flag};
				OFS_FALL_FLAG: s_nxt.rdata = {24'h00_0000, s_r.fall_flag};
				OFS_PIN_STATE: s_nxt.rdata = {16'h0000, s_r.chan_req, pin_lvl};
				OFS_PM_CTRL: s_nxt.rdata = {30'h0000_0000, s_r.ev_en, s_r.pm_on};
				OFS_PM_SRC: s_nxt.rdata = {8'h00, s_r.pm_src};
				OFS_PM_CFG: s_nxt.rdata = {8'h00, s_r.pm_cfg};
				OFS_PM_END: s_nxt.rdata = {24'h00_0000, s_r.pm_end};
				OFS_IRQ_STAT: begin
					s_nxt.rdata = {24'h00_0000, s_r.irq_stat};
					rd_clr = 1'b1;
				end
				OFS_IRQ_MASK: s_nxt.rdata = {24'h00_0000, s_r.irq_mask};
				default: s_nxt.rdata = 32'h0000_0000;
			endcase
		end
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		s_nxt.ar_rdy = !s_nxt.rvalid;

		// edge flags held, new edge beats clear
		if (wr_go && (s_r.aw_addr == OFS_RISE_FLAG)) begin
			w1c = s_r.w_strb[0] ? s_r.w_data[7:0] : 8'h00;
		end
		s_nxt.rise_flag = (s_r.rise_flag & ~w1c) | (pin_rise & ~s_r.mode);
		w1c = 8'h00;
		if (wr_go && (s_r.aw_addr == OFS_FALL_FLAG)) begin
			w1c = s_r.w_strb[0] ? s_r.w_data[7:0] : 8'h00;
		end
		s_nxt.fall_flag = (s_r.fall_flag & ~w1c) | (pin_fall & ~s_r.mode);

		req = s_r.pm_on ? term : pin_req;
		s_nxt.chan_req = req;

		// wake from pin requests, never from patterns
		s_nxt.wake = !s_r.pm_on && (|pin_req);

		// event pulse on a new match
		s_nxt.term_prev = s_r.pm_on ? term : 8'h00;
		s_nxt.cpu_event = s_r.pm_on && s_r.ev_en && (|(term & ~s_r.term_prev));

		// Sticky status on request rise; set beats read clear
		s_nxt.irq_stat = (s_r.irq_stat & {8{~rd_clr}}) | (req & ~s_r.chan_req);
		s_nxt.irq = |(s_nxt.irq_stat & s_r.irq_mask);
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= PEM_STATE_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign s_axi_awready = s_r.aw_rdy;
	assign s_axi_wready = s_r.w_rdy;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_arready = s_r.ar_rdy;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rdata = s_r.rdata;
	assign s_axi_rresp = s_r.rresp;
	assign irq_chan = s_r.chan_req;
	assign wake = s_r.wake;
	assign cpu_event_input = s_r.cpu_event;
	assign irq = s_r.irq;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_no_enable;
		(!s_r.pm_on && (s_r.rise_en == 8'h00) && (s_r.fall_en == 8'h00)) |=> (irq_chan == 8'h00);
	endproperty
	a_no_enable: assert property (p_no_enable) else $error("request without enable");

	// rising edge reaches the flag then the line
	property p_rise;
		(!s_r.pm_on && !s_r.mode[0] && s_r.rise_en[0] && pin_rise[0] && !wr_go)
			|=> s_r.rise_flag[0] ##1 (irq_chan[0] || s_r.pm_on || s_r.mode[0] || !s_r.rise_en[0]);
	endproperty
	a_rise: assert property (p_rise) else $error("rise edge not flagged");

	property p_fall;
		(!s_r.mode[2] && pin_fall[2]) |=> s_r.fall_flag[2];
	endproperty
	a_fall: assert property (p_fall) else $error("fall edge lost");

	property p_level;
		(!s_r.pm_on && s_r.mode[1] && s_r.rise_en[1]) |=> (irq_chan[1] == (s_r.fall_en[1] ==
			$past(pin_lvl[1])) || $past(s_r.fall_en[1]) != s_r.fall_en[1]);
	endproperty
	a_level: assert property (p_level) else $error("level request wrong");

	property p_wake;
		(!s_r.pm_on && (pin_req != 8'h00)) |=> wake;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake on pin request");

	property p_no_wake;
		s_r.pm_on |=> !wake;
	endproperty
	a_no_wake: assert property (p_no_wake) else $error("wake in pattern mode");

	// last term drives the top line
	property p_term;
		(s_r.pm_on && term[7]) |=> irq_chan[7];
	endproperty
	a_term: assert property (p_term) else $error("term request missing");

	// a never slice blocks its term
	property p_never;
		(s_r.pm_cfg[2:0] == COND_NEVER) |-> !term[0];
	endproperty
	a_never: assert property (p_never) else $error("never slice matched");

	// new match pulses the event next cycle
	property p_event;
		(s_r.pm_on && s_r.ev_en && term[0] && !s_r.term_prev[0]) |=> cpu_event_input;
	endproperty
	a_event: assert property (p_event) else $error("event pulse missing");

	// write and read both answered next cycle
	property p_bus;
		(wr_go |=> s_axi_bvalid) and (rd_go |=> s_axi_rvalid);
	endproperty
	a_bus: assert property (p_bus) else $error("bus answer late");

endmodule : pem_top

// ==== bench/pem_far_model.sv ====
/*
 * Far side of the pin event unit: the routed pins and the core's inputs.
 * Assumes one clock, aclk, and a synchronous active-low reset.
 */
`timescale 1ns/1ns
module pem_far_model
	import pem_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] pin_lvl,
	output logic [7:0] pin_in,
	input wire logic cpu_event_input,
	output int ev_count
);
	// ----------------------------------------------------------------
	// Pin routing and event counting
	// ----------------------------------------------------------------
	// routing fixed first
	assign pin_in = pin_lvl;

	// Counts one-cycle event pulses seen by the core
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ev_count <= 0;
		end else if (cpu_event_input === 1'b1) begin
			ev_count <= ev_count + 1;
		end
	end
endmodule : pem_far_model

// ==== bench/tb_pin_interrupt_pattern_match.sv ====
/*
 * Self-checking bench for the pin event unit over AXI4-Lite.
 * Assumes pem_top and pem_far_model are compiled before it.
 */
`timescale 1ns/1ns
module tb_pin_interrupt_pattern_match
	import pem_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, wake, cpu_event_input, irq;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, pin_lvl = '0, pin_in, irq_chan, oh, pv;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	int failures = 0, checks_done = 0, ev_count, ev0;

	pem_top dut (.aclk(aclk), .aresetn(aresetn), .pin_in(pin_in),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.irq_chan(irq_chan), .wake(wake), .cpu_event_input(cpu_event_input), .irq(irq));

	pem_far_model far (.aclk(aclk), .aresetn(aresetn), .pin_lvl(pin_lvl), .pin_in(pin_in),
		.cpu_event_input(cpu_event_input), .ev_count(ev_count));

	// ----------------------------------------------------------------
	// Clock and watchdog
	// ----------------------------------------------------------------
	initial begin
		forever #4 aclk = ~aclk;
	end

	// Cuts a hang short
	initial begin
		repeat (20000) @(posedge aclk);
		failures++;
		final_report();
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// One write, master side; waits for the answer, the watchdog ends a hang
	task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		// Let an edge pass so the next call never re-raises bready in this step
		@(posedge aclk);
	endtask : wr

	// One read, master side; waits for the answer, the watchdog ends a hang
	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		// Let an edge pass so the next call never re-raises rready in this step
		@(posedge aclk);
	endtask : rd

	task w(input logic [7:0] a, input logic [31:0] d);
		wr(a, d, rr);
	endtask : w

	task settle(input int n);
		repeat (n) @(posedge aclk);
	endtask : settle

	task end_test(input string name);
		$display("test %s done, failures so far %0d", name, failures);
	endtask : end_test

	// Expected level requests for given pins and polarity
	function automatic logic [7:0] lvl_exp(input logic [7:0] p, input logic [7:0] pol);
		return (p & pol) | (~p & ~pol);
	endfunction : lvl_exp

	// Slice conditions: first slice c0, all others rest
	function automatic logic [31:0] cfg_fill(input logic [2:0] c0, input logic [2:0] rest);
		logic [31:0] v;
		v = '0;
		for (int i = 0; i < 8; i++) v[3*i +: 3] = (i == 0) ? c0 : rest;
		return v;
	endfunction : cfg_fill

	// Slice i fed by channel i
	function automatic logic [31:0] src_all();
		logic [31:0] v;
		v = '0;
		for (int i = 0; i < 8; i++) v[3*i +: 3] = i[2:0];
		return v;
	endfunction : src_all

	task final_report();
		$display("checks %0d, failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : final_report

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(37));
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		settle(3);
		// Reset values, unmapped and misaligned places
		rd(OFS_MODE, rv, rr);
		chk(rv, 32'h0000_0000);
		wr(8'h30, 32'hffff_ffff, rr);
		chk(rr, RESP_SLVERR);
		rd(8'h02, rv, rr);
		chk(rr, RESP_SLVERR);
		w(OFS_IRQ_MASK, 32'h0000_00a5);
		rd(OFS_IRQ_MASK, rv, rr);
		chk(rv, 32'h0000_00a5);
		end_test("bus");
		// Edge channels: corners 7, 0 and 2 first, then random ones
		for (int k = 0; k < 5; k++) begin
			oh = 8'h01 << ((k == 0) ? 7 : (k < 3) ? 2 * k - 2 : $urandom_range(7, 0));
			w(OFS_MODE, 32'h0000_0000);
			w(OFS_FALL_EN, 32'h0000_0000);
			w(OFS_RISE_EN, {24'h0, oh});
			pin_lvl <= pin_lvl | oh;
			settle(8);
			rd(OFS_RISE_FLAG, rv, rr);
			chk(rv, {24'h0, oh});
			chk(irq_chan, oh);
			chk(wake, 1'b1);
			pin_lvl <= pin_lvl & ~oh;
			settle(8);
			rd(OFS_FALL_FLAG, rv, rr);
			chk(rv, {24'h0, oh});
			chk(irq_chan, oh);
			w(OFS_RISE_FLAG, {24'h0, oh});
			settle(2);
			chk(irq_chan, 8'h00);
			chk(wake, 1'b0);
			w(OFS_FALL_EN, {24'h0, oh});
			w(OFS_RISE_EN, 32'h0000_0000);
			settle(2);
			chk(irq_chan, oh);
			w(OFS_FALL_FLAG, {24'h0, oh});
			settle(2);
			chk(irq_chan, 8'h00);
		end
		end_test("edge");
		// Level channels, mixed polarity, with status and mask
		w(OFS_FALL_EN, 32'h0000_000f);
		w(OFS_MODE, 32'h0000_00ff);
		rd(OFS_IRQ_STAT, rv, rr);
		w(OFS_IRQ_MASK, 32'h0000_0000);
		pv = 8'($urandom()) | 8'h01;
		pin_lvl <= pv;
		w(OFS_RISE_EN, 32'h0000_00ff);
		settle(6);
		chk(irq_chan, lvl_exp(pv, 8'h0f));
		rd(OFS_PIN_STATE, rv, rr);
		chk(rv, {16'h0, lvl_exp(pv, 8'h0f), pv});
		chk(irq, 1'b0);
		w(OFS_IRQ_MASK, 32'h0000_00ff);
		settle(2);
		chk(irq, 1'b1);
		rd(OFS_IRQ_STAT, rv, rr);
		chk(rv, {24'h0, lvl_exp(pv, 8'h0f)});
		settle(2);
		chk(irq, 1'b0);
		w(OFS_FALL_EN, 32'h0000_00f0);
		settle(6);
		chk(irq_chan, lvl_exp(pv, 8'hf0));
		end_test("level");
		// Pattern terms: slice 0 alone, then slices 1 to 7
		w(OFS_RISE_EN, 32'h0000_0000);
		pin_lvl <= 8'h00;
		w(OFS_MODE, 32'h0000_0000);
		w(OFS_PM_SRC, src_all());
		w(OFS_PM_CFG, cfg_fill(COND_HIGH, COND_NEVER));
		w(OFS_PM_END, 32'h0000_0001);
		w(OFS_PM_CTRL, 32'h0000_0003);
		settle(4);
		ev0 = ev_count;
		pin_lvl <= 8'h01;
		settle(8);
		chk(irq_chan, 8'h01);
		chk(wake, 1'b0);
		chk(ev_count - ev0, 1);
		w(OFS_PM_CFG, cfg_fill(COND_HIGH, COND_ALWAYS));
		settle(4);
		chk(irq_chan, 8'h81);
		chk(ev_count - ev0, 2);
		w(OFS_PM_CFG, cfg_fill(COND_NEVER, COND_ALWAYS));
		settle(4);
		chk(irq_chan, 8'h80);
		pin_lvl <= 8'h00;
		settle(8);
		chk(irq_chan, 8'h80);
		chk(wake, 1'b0);
		// Sticky conditions hold a past edge until a config write
		for (int c = 1; c < 4; c++) begin
			w(OFS_PM_CFG, cfg_fill(3'(c), COND_LOW));
			settle(3);
			chk(irq_chan, 8'h80);
			pin_lvl <= 8'h01;
			settle(8);
			pin_lvl <= 8'h00;
			settle(8);
			chk(irq_chan, 8'h81);
		end
		pin_lvl <= 8'h80;
		settle(8);
		chk(irq_chan, 8'h01);
		// Edge-now slice makes a single event pulse
		w(OFS_PM_CFG, cfg_fill(COND_EDGE_NOW, COND_ALWAYS));
		settle(4);
		ev0 = ev_count;
		pin_lvl <= 8'h01;
		settle(8);
		chk(ev_count - ev0, 1);
		chk(irq_chan, 8'h80);
		chk(wake, 1'b0);
		end_test("pattern");
		final_report();
	end
endmodule : tb_pin_interrupt_pattern_match
